// ### rtl/ccc_pkg.sv
package ccc_pkg;

   // ==========================================================
   // register offsets
   localparam logic [7:0] GENERAL_CONFIG_ONE_OFS = 8'h03;
   localparam logic [7:0] CONTROL_LINK_WATCHDOG_OFS = 8'h04;
   localparam logic [7:0] SERIAL_BUS_CONTROL_ONE_OFS = 8'h05;

   // ==========================================================
   // reset values
   localparam logic [7:0] GENERAL_CONFIG_ONE_RST = 8'hF0;
   localparam logic [7:0] CONTROL_LINK_WATCHDOG_RST = 8'hFE;
   localparam logic [7:0] SERIAL_BUS_CONTROL_ONE_RST = 8'h1E;
   localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

   // ==========================================================
   // field positions, general_config_one
   localparam int GC1_RSVD_HI_BIT = 7;
   localparam int BACK_LINK_CRC_OFF_BIT = 6;
   localparam int PULL_DIRECTION_SELECT_BIT = 5;
   localparam int STROBE_FILTER_ON_BIT = 4;
   localparam int PASS_MATCHED_BIT = 3;
   localparam int EARLY_ACK_BIT = 2;
   localparam int GATE_PIXELS_BY_VALID_BIT = 1;
   localparam int GC1_RSVD_LO_BIT = 0;

   // field positions, control_link_watchdog
   localparam int CONTROL_LINK_TIMEOUT_MSB = 7;
   localparam int CONTROL_LINK_TIMEOUT_LSB = 1;
   localparam int CONTROL_LINK_TIMEOUT_OFF_BIT = 0;

   // field positions, serial_bus_control_one
   localparam int PASS_ALL_BIT = 7;
   localparam int SDA_HOLD_MSB = 6;
   localparam int SDA_HOLD_LSB = 4;
   localparam int GLITCH_DEPTH_MSB = 3;
   localparam int GLITCH_DEPTH_LSB = 0;

   // ==========================================================
   // timing
   localparam longint CLOCK_HZ = 25000000;
   localparam longint WATCHDOG_UNIT_MS = 2;
   localparam longint WATCHDOG_UNIT_CYCLES = (WATCHDOG_UNIT_MS * CLOCK_HZ + 999) / 1000;
   localparam int SDA_HOLD_STEP_NS = 50;
   localparam int GLITCH_STEP_NS = 5;
   localparam int STROBE_MIN_CYCLES = 2;

   // ==========================================================
   // widths
   localparam int PIXEL_W = 24;
   localparam int STROBE_W = 3;
   localparam int TICK_W = 32;

   // ==========================================================
   // watchdog states
   typedef enum logic [1:0] {
      WD_IDLE = 2'b00,
      WD_RUN = 2'b01,
      WD_OFF = 2'b10
   } ccc_wd_e;

   // ==========================================================
   // strobe filter state
   typedef struct packed {
      logic [STROBE_W-1:0] syncA;
      logic [STROBE_W-1:0] syncB;
      logic [STROBE_W-1:0] held;
      logic [STROBE_W-1:0] strobeOut;
   } ccc_filt_s;

   // ==========================================================
   // top state
   typedef struct packed {
      logic [7:0] generalConfigOne;
      logic [7:0] controlLinkWatchdog;
      logic [7:0] serialBusControlOne;
      logic [7:0] readData;
      ccc_wd_e wdState;
      logic [TICK_W-1:0] tickCount;
      logic [6:0] unitCount;
      logic txnAbort;
      logic forwardTxn;
      logic ackWrite;
      logic [PIXEL_W-1:0] pixA;
      logic [PIXEL_W-1:0] pixB;
      logic [PIXEL_W-1:0] pixC;
      logic [PIXEL_W-1:0] pixD;
      logic [PIXEL_W-1:0] pixelOut;
      logic [STROBE_W-1:0] strobesOut;
   } ccc_top_s;

endpackage

// ### rtl/ccc_strobe_filter.sv
module ccc_strobe_filter (
   input wire logic clock,
   input wire logic rst,
   input wire logic filterOn,
   input wire logic [ccc_pkg::STROBE_W-1:0] strobeIn,
   output logic [ccc_pkg::STROBE_W-1:0] strobeOut
);

   ccc_pkg::ccc_filt_s st_r;
   ccc_pkg::ccc_filt_s st_nxt;

   // ==========================================================
   // synchroniser and one-cycle pulse rejection
   always_comb begin
      st_nxt = st_r;
      st_nxt.syncA = strobeIn;
      st_nxt.syncB = st_r.syncA;
      st_nxt.held = st_r.syncB;
      for (int i = 0; i < ccc_pkg::STROBE_W; i++) begin
         // a level must be seen on two successive samples to pass
         if (!filterOn || (st_r.syncB[i] == st_r.held[i])) begin
            st_nxt.strobeOut[i] = st_r.held[i];
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign strobeOut = st_r.strobeOut;

endmodule // ccc_strobe_filter

// ### rtl/ccc_config_regs.sv
// Summary of operation
// - crc-off bit at 1 disables back-link crc, at 0 enables; resets to 1.
// - pull-direction bit at 1 pulls undriven inputs down, at 0 up; resets 1.
// - filter on (reset) rejects strobe pulses under two cycles; off passes all.
// - matched pass-through bit forwards transactions whose address decode matches; reset off.
// - early-ack bit acknowledges writes whether or not link is locked; reset off.
// - protection-capable partner: pixels always gated by valid strobe; gating bit ignored.
// - other partner: pixels ungated unless gating bit set; bit resets to 0.
// - unfinished control transaction aborted when watchdog timeout expires, unless disabled.
// - seven-bit timeout field counts two-millisecond units; resets to 0x7F.
// - watchdog stopped while disable bit is 1, runs while 0 (reset).
// - pass-all bit forwards every transaction across control channel; reset off.
// - three-bit sda hold field in 50 ns steps; resets to 0x1.
// - four-bit glitch-filter field in 5 ns steps; resets to 0xE.
// - register digital reset returns all fields here to defaults.
module ccc_config_regs #(
   parameter int PIXEL_BITS = ccc_pkg::PIXEL_W,
   parameter longint WATCHDOG_UNIT_CYCLES = ccc_pkg::WATCHDOG_UNIT_CYCLES
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic regsResetPulse,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrEn,
   input wire logic regRdEn,
   output logic [7:0] regRdData,
   input wire logic txnStart,
   input wire logic txnDone,
   output logic txnAbort,
   input wire logic addrMatch,
   input wire logic txnRequest,
   output logic forwardTxn,
   input wire logic writeReq,
   input wire logic linkLocked,
   output logic ackWrite,
   input wire logic remoteHasProtection,
   input wire logic pixelValidStrobe,
   input wire logic lineSync,
   input wire logic frameSync,
   input wire logic [PIXEL_BITS-1:0] pixelIn,
   output logic pixelValidOut,
   output logic lineSyncOut,
   output logic frameSyncOut,
   output logic [PIXEL_BITS-1:0] pixelOut,
   output logic backLinkCrcOn,
   output logic pullDirectionSelect,
   output logic [2:0] sdaHoldSteps,
   output logic [3:0] glitchDepthSteps
);

   ccc_pkg::ccc_top_s st_r;
   ccc_pkg::ccc_top_s st_nxt;
   logic [ccc_pkg::STROBE_W-1:0] filtered;
   logic [ccc_pkg::TICK_W-1:0] tickLast;

   assign tickLast = ccc_pkg::TICK_W'(WATCHDOG_UNIT_CYCLES - 1);

   // ==========================================================
   // register helpers
   function automatic logic [7:0] reset_value(input logic [7:0] ofs);
      case (ofs)
         ccc_pkg::GENERAL_CONFIG_ONE_OFS: reset_value = ccc_pkg::GENERAL_CONFIG_ONE_RST;
         ccc_pkg::CONTROL_LINK_WATCHDOG_OFS: reset_value = ccc_pkg::CONTROL_LINK_WATCHDOG_RST;
         ccc_pkg::SERIAL_BUS_CONTROL_ONE_OFS: reset_value = ccc_pkg::SERIAL_BUS_CONTROL_ONE_RST;
         default: reset_value = ccc_pkg::UNMAPPED_READ_VALUE;
      endcase
   endfunction

   function automatic ccc_pkg::ccc_top_s defaults();
      ccc_pkg::ccc_top_s d;
      d = '0;
      d.generalConfigOne = reset_value(ccc_pkg::GENERAL_CONFIG_ONE_OFS);
      d.controlLinkWatchdog = reset_value(ccc_pkg::CONTROL_LINK_WATCHDOG_OFS);
      d.serialBusControlOne = reset_value(ccc_pkg::SERIAL_BUS_CONTROL_ONE_OFS);
      d.wdState = ccc_pkg::WD_IDLE;
      return d;
   endfunction

   // ==========================================================
   // sync strobe filtering
   ccc_strobe_filter u_filter (
      .clock(clock),
      .rst(rst),
      .filterOn(st_r.generalConfigOne[ccc_pkg::STROBE_FILTER_ON_BIT]),
      .strobeIn({frameSync, lineSync, pixelValidStrobe}),
      .strobeOut(filtered)
   );

   // ==========================================================
   // next state
   always_comb begin
      logic gateOn;
      logic [6:0] timeoutUnits;
      logic wdOff;
      gateOn = 1'b0;
      timeoutUnits = 7'h00;
      wdOff = 1'b0;
      st_nxt = st_r;

      // register port
      if (regWrEn) begin
         case (regAddr)
            // reserved bits are stored and read back only
            ccc_pkg::GENERAL_CONFIG_ONE_OFS: st_nxt.generalConfigOne = regWrData;
            ccc_pkg::CONTROL_LINK_WATCHDOG_OFS: st_nxt.controlLinkWatchdog = regWrData;
            ccc_pkg::SERIAL_BUS_CONTROL_ONE_OFS: st_nxt.serialBusControlOne = regWrData;
            default: st_nxt.readData = st_r.readData;
         endcase
      end
      if (regRdEn) begin
         case (regAddr)
            ccc_pkg::GENERAL_CONFIG_ONE_OFS: st_nxt.readData = st_r.generalConfigOne;
            ccc_pkg::CONTROL_LINK_WATCHDOG_OFS: st_nxt.readData = st_r.controlLinkWatchdog;
            ccc_pkg::SERIAL_BUS_CONTROL_ONE_OFS: st_nxt.readData = st_r.serialBusControlOne;
            default: st_nxt.readData = ccc_pkg::UNMAPPED_READ_VALUE;
         endcase
      end

      // transaction forwarding and write acknowledge
      st_nxt.forwardTxn = txnRequest &&
         (st_r.serialBusControlOne[ccc_pkg::PASS_ALL_BIT] ||
          (st_r.generalConfigOne[ccc_pkg::PASS_MATCHED_BIT] && addrMatch));
      st_nxt.ackWrite = writeReq &&
         (linkLocked || st_r.generalConfigOne[ccc_pkg::EARLY_ACK_BIT]);

      // control channel watchdog
      timeoutUnits = st_r.controlLinkWatchdog[ccc_pkg::CONTROL_LINK_TIMEOUT_MSB:
                                              ccc_pkg::CONTROL_LINK_TIMEOUT_LSB];
      wdOff = st_r.controlLinkWatchdog[ccc_pkg::CONTROL_LINK_TIMEOUT_OFF_BIT];
      st_nxt.txnAbort = 1'b0;
      case (st_r.wdState)
         ccc_pkg::WD_IDLE: begin
            if (wdOff) begin
               st_nxt.wdState = ccc_pkg::WD_OFF;
            end else if (txnStart && !txnDone) begin
               st_nxt.wdState = ccc_pkg::WD_RUN;
               st_nxt.tickCount = '0;
               st_nxt.unitCount = 7'h00;
            end
         end
         ccc_pkg::WD_RUN: begin
            if (wdOff) begin
               st_nxt.wdState = ccc_pkg::WD_OFF;
            end else if (txnDone) begin
               // completion in the expiry cycle is not aborted
               st_nxt.wdState = ccc_pkg::WD_IDLE;
            end else if (st_r.tickCount == tickLast) begin
               st_nxt.tickCount = '0;
               st_nxt.unitCount = st_r.unitCount + 7'h01;
               // a zero timeout never expires
               if ((timeoutUnits != 7'h00) && ((st_r.unitCount + 7'h01) == timeoutUnits)) begin
                  st_nxt.txnAbort = 1'b1;
                  st_nxt.wdState = ccc_pkg::WD_IDLE;
               end
            end else begin
               st_nxt.tickCount = st_r.tickCount + ccc_pkg::TICK_W'(1);
            end
         end
         ccc_pkg::WD_OFF: begin
            st_nxt.tickCount = '0;
            st_nxt.unitCount = 7'h00;
            if (!wdOff) begin
               st_nxt.wdState = ccc_pkg::WD_IDLE;
            end
         end
         default: st_nxt.wdState = ccc_pkg::WD_IDLE;
      endcase

      // pixel path aligned with the filtered strobes
      st_nxt.pixA = pixelIn;
      st_nxt.pixB = st_r.pixA;
      st_nxt.pixC = st_r.pixB;
      st_nxt.pixD = st_r.pixC;
      st_nxt.strobesOut = filtered;
      gateOn = remoteHasProtection ||
               st_r.generalConfigOne[ccc_pkg::GATE_PIXELS_BY_VALID_BIT];
      if (gateOn && !filtered[0]) begin
         st_nxt.pixelOut = '0;
      end else begin
         st_nxt.pixelOut = st_r.pixD;
      end

      if (regsResetPulse) begin
         st_nxt = defaults();
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         st_r <= defaults();
      end else begin
         st_r <= st_nxt;
      end
   end

   // ==========================================================
   // outputs
   assign regRdData = st_r.readData;
   assign txnAbort = st_r.txnAbort;
   assign forwardTxn = st_r.forwardTxn;
   assign ackWrite = st_r.ackWrite;
   assign pixelOut = st_r.pixelOut;
   assign pixelValidOut = st_r.strobesOut[0];
   assign lineSyncOut = st_r.strobesOut[1];
   assign frameSyncOut = st_r.strobesOut[2];
   assign backLinkCrcOn = ~st_r.generalConfigOne[ccc_pkg::BACK_LINK_CRC_OFF_BIT];
   assign pullDirectionSelect = st_r.generalConfigOne[ccc_pkg::PULL_DIRECTION_SELECT_BIT];
   assign sdaHoldSteps = st_r.serialBusControlOne[ccc_pkg::SDA_HOLD_MSB:ccc_pkg::SDA_HOLD_LSB];
   assign glitchDepthSteps = st_r.serialBusControlOne[ccc_pkg::GLITCH_DEPTH_MSB:ccc_pkg::GLITCH_DEPTH_LSB];

endmodule // ccc_config_regs

// ### verification/ccc_config_regs_sva.sv
module ccc_config_regs_sva (
   input wire logic clock,
   input wire logic rst,
   input wire logic regsResetPulse,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrEn,
   input wire logic regRdEn,
   input wire logic [7:0] regRdData,
   input wire logic txnAbort,
   input wire logic addrMatch,
   input wire logic txnRequest,
   input wire logic forwardTxn,
   input wire logic writeReq,
   input wire logic linkLocked,
   input wire logic ackWrite,
   input wire logic backLinkCrcOn,
   input wire logic pullDirectionSelect,
   input wire logic [2:0] sdaHoldSteps,
   input wire logic [3:0] glitchDepthSteps
);
   timeunit 1ns;
   timeprecision 1ps;
   // =====
   // register shadow
   logic [7:0] gc, wd, bc, rv;
   logic clr, w3, w5;
   assign clr = rst | regsResetPulse;
   assign w3 = regWrEn && regAddr == 8'h03 && !clr;
   assign w5 = regWrEn && regAddr == 8'h05 && !clr;
   assign rv = regAddr == 8'h03 ? gc : regAddr == 8'h04 ? wd : regAddr == 8'h05 ? bc : 8'h00;
   always_ff @(posedge clock) begin
      gc <= clr ? 8'hF0 : w3 ? regWrData : gc;
      wd <= clr ? 8'hFE : (regWrEn && regAddr == 8'h04) ? regWrData : wd;
      bc <= clr ? 8'h1E : w5 ? regWrData : bc;
   end
   // =====
   // properties
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   AST_CRC_BIT: assert property (w3 |=> backLinkCrcOn == !$past(regWrData[6]))
      else $error("crc enable wrong");
   AST_PULL_BIT: assert property (w3 |=> pullDirectionSelect == $past(regWrData[5]))
      else $error("pull direction wrong");
   AST_HOLD_FIELD: assert property (w5 |=> sdaHoldSteps == $past(regWrData[6:4]))
      else $error("sda hold wrong");
   AST_GLITCH_FIELD: assert property (w5 |=> glitchDepthSteps == $past(regWrData[3:0]))
      else $error("glitch depth wrong");
   AST_READ: assert property (regRdEn && !regsResetPulse |=> regRdData == $past(rv))
      else $error("read data wrong");
   AST_FWD: assert property (!$past(clr) |-> forwardTxn == $past(txnRequest & (bc[7] | gc[3] & addrMatch)))
      else $error("forward wrong");
   AST_ACK: assert property (!$past(clr) |-> ackWrite == $past(writeReq & (linkLocked | gc[2])))
      else $error("ack wrong");
   AST_ABORT_PULSE: assert property (txnAbort |=> !txnAbort)
      else $error("abort too long");
   AST_WD_OFF: assert property (wd[0] && $past(wd[0]) |-> !txnAbort)
      else $error("abort while disabled");
   AST_DEFAULTS: assert property (regsResetPulse |=> !backLinkCrcOn && pullDirectionSelect && sdaHoldSteps == 3'h1
      && glitchDepthSteps == 4'hE)
      else $error("defaults wrong");
endmodule // ccc_config_regs_sva

bind ccc_config_regs ccc_config_regs_sva u_sva (.clock(clock), .rst(rst), .regsResetPulse(regsResetPulse),
   .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
   .txnAbort(txnAbort), .addrMatch(addrMatch), .txnRequest(txnRequest), .forwardTxn(forwardTxn),
   .writeReq(writeReq), .linkLocked(linkLocked), .ackWrite(ackWrite), .backLinkCrcOn(backLinkCrcOn),
   .pullDirectionSelect(pullDirectionSelect), .sdaHoldSteps(sdaHoldSteps), .glitchDepthSteps(glitchDepthSteps));

// ### verification/ccc_remote_model.sv
module ccc_remote_model (
   input wire logic clock,
   input wire logic go,
   input wire logic [7:0] lat,
   output logic txnStart,
   output logic txnDone
);
   timeunit 1ns;
   timeprecision 1ps;
   // lat of zero means the far end never answers
   logic [7:0] n = 8'h00;
   assign txnStart = go;
   always @(posedge clock) begin
      if (go) n <= lat;
      else if (n != 8'h00) n <= n - 8'h01;
   end
   initial txnDone = 1'b0;
   always @(negedge clock) txnDone <= n == 8'h01;
endmodule // ccc_remote_model

// ### verification/control_channel_config_regs_tb.sv
module control_channel_config_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock, rst = 1'b1, regsResetPulse = 1'b0, regWrEn = 1'b0, regRdEn = 1'b0, go = 1'b0;
   logic addrMatch = 1'b0, txnRequest = 1'b0, writeReq = 1'b0, linkLocked = 1'b0, remoteHasProtection = 1'b0;
   logic pixelValidStrobe = 1'b0, lineSync = 1'b0, frameSync = 1'b0;
   logic txnStart, txnDone, txnAbort, forwardTxn, ackWrite, pixelValidOut, lineSyncOut, frameSyncOut;
   logic backLinkCrcOn, pullDirectionSelect;
   logic [7:0] regAddr = 8'h00, regWrData = 8'h00, lat = 8'h00, regRdData;
   logic [2:0] sdaHoldSteps;
   logic [3:0] glitchDepthSteps;
   logic [23:0] pixelIn = 24'h000000, pixelOut;
   int errors = 0, check_count = 0, cycles = 0;
   ccc_config_regs #(.WATCHDOG_UNIT_CYCLES(4)) dut (.clock(clock), .rst(rst), .regsResetPulse(regsResetPulse),
      .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
      .txnStart(txnStart), .txnDone(txnDone), .txnAbort(txnAbort), .addrMatch(addrMatch),
      .txnRequest(txnRequest), .forwardTxn(forwardTxn), .writeReq(writeReq), .linkLocked(linkLocked),
      .ackWrite(ackWrite), .remoteHasProtection(remoteHasProtection), .pixelValidStrobe(pixelValidStrobe),
      .lineSync(lineSync), .frameSync(frameSync), .pixelIn(pixelIn), .pixelValidOut(pixelValidOut),
      .lineSyncOut(lineSyncOut), .frameSyncOut(frameSyncOut), .pixelOut(pixelOut),
      .backLinkCrcOn(backLinkCrcOn), .pullDirectionSelect(pullDirectionSelect),
      .sdaHoldSteps(sdaHoldSteps), .glitchDepthSteps(glitchDepthSteps));
   ccc_remote_model peer (.clock(clock), .go(go), .lat(lat), .txnStart(txnStart), .txnDone(txnDone));
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == 4000) begin
         errors++;
         complete_run();
      end
   end
   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string name, input logic [23:0] e, input logic [23:0] g);
      check_count++;
      if (g !== e) begin
         errors++;
         $display("BAD %s expected %h seen %h", name, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clock);
      regAddr = a;
      regWrData = d;
      regWrEn = 1'b1;
      @(negedge clock);
      regWrEn = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge clock);
      regAddr = a;
      regRdEn = 1'b1;
      @(negedge clock);
      regRdEn = 1'b0;
      chk("read", 24'(e), 24'(regRdData));
   endtask
   task automatic t_defaults();
      rd(8'h03, 8'hF0);
      rd(8'h04, 8'hFE);
      rd(8'h05, 8'h1E);
      chk("crc", 24'h0, 24'(backLinkCrcOn));
      chk("pull", 24'h1, 24'(pullDirectionSelect));
      chk("hold", 24'h1, 24'(sdaHoldSteps));
      chk("glitch", 24'hE, 24'(glitchDepthSteps));
      $display("defaults done");
   endtask
   task automatic t_regs();
      for (int i = 3; i < 6; i++) begin
         wr(8'(i), 8'hA5);
         rd(8'(i), 8'hA5);
      end
      chk("crc", 24'h1, 24'(backLinkCrcOn));
      chk("hold", 24'h2, 24'(sdaHoldSteps));
      chk("glitch", 24'h5, 24'(glitchDepthSteps));
      wr(8'h06, 8'h5A);
      rd(8'h06, 8'h00);
      @(negedge clock);
      regsResetPulse = 1'b1;
      @(negedge clock);
      regsResetPulse = 1'b0;
      rd(8'h04, 8'hFE);
      rd(8'h03, 8'hF0);
      rd(8'h05, 8'h1E);
      $display("registers done");
   endtask
   task automatic t_fwd();
      for (int i = 0; i < 16; i++) begin
         wr(8'h03, {4'hF, i[2], i[2], 2'h0});
         wr(8'h05, {i[3], 7'h1E});
         addrMatch = i[1];
         linkLocked = i[1];
         txnRequest = i[0];
         writeReq = i[0];
         @(negedge clock);
         chk("fwd", 24'(i[0] & (i[3] | i[2] & i[1])), 24'(forwardTxn));
         chk("ack", 24'(i[0] & (i[1] | i[2])), 24'(ackWrite));
      end
      $display("forward done");
   endtask
   task automatic t_filter();
      int seen;
      for (int i = 0; i < 4; i++) begin
         wr(8'h03, {3'h7, i[0], 4'h0});
         seen = 0;
         pixelValidStrobe = 1'b1;
         lineSync = 1'b1;
         frameSync = 1'b1;
         repeat (1 + i[1]) @(negedge clock);
         pixelValidStrobe = 1'b0;
         lineSync = 1'b0;
         frameSync = 1'b0;
         repeat (10) begin
            @(negedge clock);
            seen += lineSyncOut + frameSyncOut + pixelValidOut;
         end
         // each of the three strobes passes for as many cycles as it was driven, except a one-cycle pulse with the filter on, which passes for none
         chk("sync", 24'((!i[0] || i[1]) ? 3 * (1 + i[1]) : 0), 24'(seen));
      end
      $display("filter done");
   endtask
   task automatic t_pix();
      pixelIn = 24'hC3A5F0;
      for (int i = 0; i < 4; i++) begin
         remoteHasProtection = i[1];
         wr(8'h03, {6'h3C, i[0], 1'b0});
         repeat (7) @(negedge clock);
         chk("pixel", (i[1] | i[0]) ? 24'h000000 : 24'hC3A5F0, pixelOut);
      end
      pixelValidStrobe = 1'b1;
      repeat (7) @(negedge clock);
      chk("pixel", 24'hC3A5F0, pixelOut);
      chk("valid", 24'h1, 24'(pixelValidOut));
      $display("pixels done");
   endtask
   task automatic t_wd(input logic [7:0] w, input logic [7:0] l, input int at);
      wr(8'h04, w);
      lat = l;
      @(negedge clock);
      go = 1'b1;
      @(negedge clock);
      go = 1'b0;
      for (int k = 1; k < 16; k++) begin
         chk("abort", 24'(k == at), 24'(txnAbort));
         @(negedge clock);
      end
      $display("watchdog done");
   endtask
   initial begin
      repeat (4) @(negedge clock);
      rst = 1'b0;
      t_defaults();
      t_regs();
      t_fwd();
      t_filter();
      t_pix();
      t_wd(8'h04, 8'h00, 9);
      t_wd(8'h06, 8'h00, 13);
      t_wd(8'h04, 8'h05, 0);
      t_wd(8'h05, 8'h00, 0);
      complete_run();
   end
endmodule // control_channel_config_regs_tb
